//--- design/exec_pkg.sv
package exec_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned WORD_W = 16;
   localparam int unsigned BYTE_W = 8;
   localparam int unsigned OFS_W  = 10;

   // ----------------------------------------------------------------
   // register byte offsets
   // ----------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_INSTR = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_PC    = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_SR    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_SRC   = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_DST   = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_STAT  = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_CNT   = 8'h18;

   // ----------------------------------------------------------------
   // status word layout
   // ----------------------------------------------------------------
   localparam int unsigned SR_C      = 0;
   localparam int unsigned SR_Z      = 1;
   localparam int unsigned SR_N      = 2;
   localparam int unsigned SR_GIE    = 3;
   localparam int unsigned SR_CORE_HALT_BIT = 4;
   localparam int unsigned SR_CRYSTAL_STOP_BIT = 5;
   localparam int unsigned SR_V      = 8;
   localparam logic [WORD_W-1:0] SR_MASK = 16'h013F;

   // execution status bits
   localparam int unsigned ST_TAKEN = 0;
   localparam int unsigned ST_JUMP  = 1;
   localparam int unsigned ST_MOVE  = 2;
   localparam int unsigned ST_UNDEF = 3;
   localparam int unsigned ST_IDLE  = 4;
   localparam int unsigned ST_W     = 5;

   // ----------------------------------------------------------------
   // reset values
   // ----------------------------------------------------------------
   localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
   localparam logic [ST_W-1:0]   STAT_RST = 5'h00;

   // ----------------------------------------------------------------
   // instruction encoding
   // ----------------------------------------------------------------
   localparam logic [2:0]        JMP_OPC = 3'h1;
   localparam logic [3:0]        MOV_OPC = 4'h4;
   localparam int unsigned       BW_BIT  = 6;
   localparam int unsigned       AD_BIT  = 7;
   localparam logic [3:0]        CG_REG  = 4'h3;
   localparam logic [WORD_W-1:0] ZERO_W  = 16'h0000;

   typedef enum logic [2:0] {
      COND_NE  = 3'h0,
      COND_EQ  = 3'h1,
      COND_NC  = 3'h2,
      COND_C   = 3'h3,
      COND_N   = 3'h4,
      COND_GE  = 3'h5,
      COND_L   = 3'h6,
      COND_ALL = 3'h7
   } cond_type;

   function automatic logic is_jump(input logic [WORD_W-1:0] ins);
      is_jump = (ins[15:13] == JMP_OPC);
   endfunction

   function automatic logic is_move(input logic [WORD_W-1:0] ins);
      is_move = (ins[15:12] == MOV_OPC);
   endfunction

endpackage

//--- design/exec_if.sv
`timescale 1ns/10ps
`default_nettype none
interface exec_if;
   import exec_pkg::*;

   logic [WORD_W-1:0] instr;
   logic [WORD_W-1:0] pc;
   logic [WORD_W-1:0] sr;
   logic [WORD_W-1:0] src;
   logic [WORD_W-1:0] dst_old;
   logic              taken;
   logic [WORD_W-1:0] target;
   logic [WORD_W-1:0] mov_val;
   logic              mov_wr;

   modport core (output instr, pc, sr, src, dst_old, input taken, target, mov_val, mov_wr);
   modport br   (input instr, pc, sr, output taken, target);
   modport mv   (input instr, src, dst_old, output mov_val, mov_wr);
endinterface
`default_nettype wire

//--- design/branch_unit.sv
`timescale 1ns/10ps
`default_nettype none
module branch_unit
   import exec_pkg::*;
(
   exec_if.br x
);

   logic              flag_xor;
   logic [WORD_W-1:0] step;

   assign flag_xor = x.sr[SR_N] ^ x.sr[SR_V];

   // word offset doubled to a byte step, sign kept
   assign step = {{(WORD_W-OFS_W-1){x.instr[OFS_W-1]}}, x.instr[OFS_W-1:0], 1'b0};

   always_comb
   begin
      case (cond_type'(x.instr[12:10]))
         COND_NE  : x.taken = ~x.sr[SR_Z];
         COND_EQ  : x.taken = x.sr[SR_Z];
         COND_NC  : x.taken = ~x.sr[SR_C];
         COND_C   : x.taken = x.sr[SR_C];
         COND_N   : x.taken = x.sr[SR_N];
         COND_GE  : x.taken = ~flag_xor;
         COND_L   : x.taken = flag_xor;
         COND_ALL : x.taken = 1'b1;
         default  : x.taken = 1'b0;
      endcase
   end

   assign x.target = x.taken ? x.pc + step : x.pc;

endmodule
`default_nettype wire

//--- design/move_unit.sv
`timescale 1ns/10ps
`default_nettype none
module move_unit
   import exec_pkg::*;
(
   exec_if.mv x
);

   logic byte_op;
   logic reg_dst;

   assign byte_op = x.instr[BW_BIT];
   assign reg_dst = ~x.instr[AD_BIT];

   always_comb
   begin
      // byte form moves the low byte; a register target clears its high byte
      if (byte_op)
      begin
         if (reg_dst)
            x.mov_val = {{BYTE_W{1'b0}}, x.src[BYTE_W-1:0]};
         else
            x.mov_val = {x.dst_old[WORD_W-1:BYTE_W], x.src[BYTE_W-1:0]};
      end
      else
      begin
         x.mov_val = x.src;
      end
   end

   // constant-generator target absorbs the write
   assign x.mov_wr = ~(reg_dst && (x.instr[3:0] == CG_REG));

endmodule
`default_nettype wire

//--- design/branch_move_exec.sv
// Functional notes
// - jump offset is a 10-bit signed low field; taken adds twice it to pc
// - carry jump branches when carry is 1, else falls through
// - no-carry jump branches when carry is 0, else falls through
// - equal jump branches when zero flag set, else falls through
// - not-equal jump branches when zero flag clear, else falls through
// - signed greater-or-equal branches when negative xor overflow is 0
// - signed less-than branches when negative xor overflow is 1
// - negative jump branches when negative flag is 1
// - unconditional jump always adds the scaled offset, reach -512 to +511 words
// - no jump changes any status flag
// - move copies source into destination, source unchanged
// - move keeps mode bits and arithmetic flags unchanged
// - idle instruction is a move of zero into register 3, no effect
`timescale 1ns/10ps
`default_nettype none
module branch_move_exec
   import exec_pkg::*;
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              nrst,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [DATA_W-1:0] wdata,
   input  wire logic              wr,
   input  wire logic              rd,
   output var  logic [DATA_W-1:0] rdata,
   // execution event
   output var  logic              exec_done
);

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_WAIT = 2'b01,
      ST_EXEC = 2'b10
   } state_type;

   state_type         state_q;
   state_type         state_d;
   logic [WORD_W-1:0] instr_q;
   logic [WORD_W-1:0] pc_q;
   logic [WORD_W-1:0] sr_q;
   logic [WORD_W-1:0] src_q;
   logic [WORD_W-1:0] dst_q;
   logic [ST_W-1:0]   stat_q;
   logic [ST_W-1:0]   stat_d;
   logic [WORD_W-1:0] cnt_q;
   logic [DATA_W-1:0] rdata_q;
   logic [DATA_W-1:0] rdata_d;
   logic              done_q;

   logic              executing;
   logic              jump_ins;
   logic              move_ins;
   logic              idle_ins;

   exec_if x ();

   // ----------------------------------------------------------------
   // sub-units
   // ----------------------------------------------------------------
   branch_unit u_branch
   (
      .x (x.br)
   );

   move_unit u_move
   (
      .x (x.mv)
   );

   assign x.instr   = instr_q;
   assign x.pc      = pc_q;
   assign x.sr      = sr_q;
   assign x.src     = src_q;
   assign x.dst_old = dst_q;

   assign executing = (state_q == ST_EXEC);
   assign jump_ins  = is_jump(instr_q);
   assign move_ins  = is_move(instr_q);
   assign idle_ins  = move_ins && !x.mov_wr;

   function automatic logic hit(input logic [ADDR_W-1:0] a,
                                input logic [ADDR_W-1:0] ofs);
      hit = (a == ofs);
   endfunction

   // ----------------------------------------------------------------
   // sequencer
   // ----------------------------------------------------------------
   always_comb
   begin
      case (state_q)
         ST_WAIT : state_d = (wr && hit(addr, OFS_INSTR)) ? ST_EXEC : ST_WAIT;
         ST_EXEC : state_d = (wr && hit(addr, OFS_INSTR)) ? ST_EXEC : ST_WAIT;
         default : state_d = ST_WAIT;
      endcase
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         state_q <= ST_WAIT;
      else
         state_q <= state_d;
   end

   // ----------------------------------------------------------------
   // instruction and source operand
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         instr_q <= WORD_RST;
      else if (wr && hit(addr, OFS_INSTR))
         instr_q <= wdata[WORD_W-1:0];
   end

   // source is only read by a move, never written back
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         src_q <= WORD_RST;
      else if (wr && hit(addr, OFS_SRC))
         src_q <= wdata[WORD_W-1:0];
   end

   // ----------------------------------------------------------------
   // program counter
   // ----------------------------------------------------------------
   // pc holds the address after the jump word; execution wins over a bus write
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         pc_q <= WORD_RST;
      else if (executing && jump_ins)
         pc_q <= x.target;
      else if (wr && hit(addr, OFS_PC))
         pc_q <= wdata[WORD_W-1:0];
   end

   // ----------------------------------------------------------------
   // status word
   // ----------------------------------------------------------------
   // only software writes it: jumps and moves leave every flag and mode bit
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sr_q <= WORD_RST;
      else if (wr && hit(addr, OFS_SR))
         sr_q <= wdata[WORD_W-1:0] & SR_MASK;
   end

   // ----------------------------------------------------------------
   // destination operand
   // ----------------------------------------------------------------
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         dst_q <= WORD_RST;
      else if (executing && move_ins && x.mov_wr)
         dst_q <= x.mov_val;
      else if (wr && hit(addr, OFS_DST))
         dst_q <= wdata[WORD_W-1:0];
   end

   // ----------------------------------------------------------------
   // execution status and counter
   // ----------------------------------------------------------------
   always_comb
   begin
      stat_d = STAT_RST;
      if (jump_ins)
      begin
         stat_d[ST_JUMP]  = 1'b1;
         stat_d[ST_TAKEN] = x.taken;
      end
      else if (move_ins)
      begin
         stat_d[ST_MOVE] = 1'b1;
         stat_d[ST_IDLE] = idle_ins;
      end
      else
      begin
         stat_d[ST_UNDEF] = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         stat_q <= STAT_RST;
      else if (executing)
         stat_q <= stat_d;
   end

   // counts taken jumps; software may preset it, a taken jump wins
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         cnt_q <= WORD_RST;
      else if (executing && jump_ins && x.taken)
         cnt_q <= cnt_q + 16'h0001;
      else if (wr && hit(addr, OFS_CNT))
         cnt_q <= wdata[WORD_W-1:0];
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         done_q <= 1'b0;
      else
         done_q <= executing;
   end

   // ----------------------------------------------------------------
   // read port
   // ----------------------------------------------------------------
   always_comb
   begin
      rdata_d = '0;
      if (rd)
      begin
         case (addr)
            OFS_INSTR : rdata_d[WORD_W-1:0] = instr_q;
            OFS_PC    : rdata_d[WORD_W-1:0] = pc_q;
            OFS_SR    : rdata_d[WORD_W-1:0] = sr_q;
            OFS_SRC   : rdata_d[WORD_W-1:0] = src_q;
            OFS_DST   : rdata_d[WORD_W-1:0] = dst_q;
            OFS_STAT  : rdata_d[ST_W-1:0]   = stat_q;
            OFS_CNT   : rdata_d[WORD_W-1:0] = cnt_q;
            default   : rdata_d = '0;
         endcase
      end
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         rdata_q <= '0;
      else
         rdata_q <= rdata_d;
   end

   assign rdata     = rdata_q;
   assign exec_done = done_q;

endmodule
`default_nettype wire

//--- verif/exec_asserts.sv
`timescale 1ns/10ps
`default_nettype none
module exec_asserts
   import exec_pkg::*;
(
   // clock and reset
   input wire logic              clk,
   input wire logic              nrst,
   // register port
   input wire logic [ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] wdata,
   input wire logic              wr,
   input wire logic              rd,
   input wire logic [DATA_W-1:0] rdata,
   // execution event
   input wire logic              exec_done
);
   logic [WORD_W-1:0] sr_q;
   logic [WORD_W-1:0] src_q;
   logic              go;

   assign go = wr && addr == OFS_INSTR;

   // ----
   // shadows of what only software writes
   // ----
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         sr_q <= WORD_RST;
      else if (wr && addr == OFS_SR)
         sr_q <= wdata[WORD_W-1:0] & SR_MASK;
   end

   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
         src_q <= WORD_RST;
      else if (wr && addr == OFS_SRC)
         src_q <= wdata[WORD_W-1:0];
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   a_done_after_go: assert property (go |-> ##2 exec_done)
      else $error("no done after instruction");
   a_done_has_cause: assert property (exec_done |-> $past(go, 2))
      else $error("done without instruction");
   a_done_one_pulse: assert property (exec_done && !$past(go) |=> !exec_done)
      else $error("done longer than one cycle");
   a_rdata_idle: assert property (!$past(rd) |-> rdata == 32'h00000000)
      else $error("read data outside read slot");
   a_unmapped_zero: assert property ($past(rd && addr > OFS_CNT) |-> rdata == 32'h00000000)
      else $error("unmapped read not zero");
   a_stat_width: assert property ($past(rd && addr == OFS_STAT) |-> rdata[31:ST_W] == 27'h0)
      else $error("status read too wide");
   a_flags_kept: assert property ($past(rd && addr == OFS_SR) |-> rdata == {16'h0000, $past(sr_q)})
      else $error("status word changed by execution");
   a_source_kept: assert property ($past(rd && addr == OFS_SRC) |-> rdata == {16'h0000, $past(src_q)})
      else $error("move source changed");
endmodule

bind branch_move_exec exec_asserts chk_u (
   .clk       (clk),
   .nrst      (nrst),
   .addr      (addr),
   .wdata     (wdata),
   .wr        (wr),
   .rd        (rd),
   .rdata     (rdata),
   .exec_done (exec_done)
);
`default_nettype wire

//--- verif/testbench.sv
`timescale 1ns/10ps
`default_nettype none
module testbench
   import exec_pkg::*;
;
   logic              clk;
   logic              nrst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [DATA_W-1:0] rdata;
   logic              exec_done;
   int                n_mismatch;
   int                tests_run;
   int                cyc;
   int                n_taken;

   branch_move_exec dut_u (
      .clk       (clk),
      .nrst      (nrst),
      .addr      (addr),
      .wdata     (wdata),
      .wr        (wr),
      .rd        (rd),
      .rdata     (rdata),
      .exec_done (exec_done)
   );

   // ----
   // bus tasks
   // ----
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic put(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] d);
      @(posedge clk);
      addr <= a;
      wdata <= {16'h0000, d};
      wr <= 1'b1;
      @(posedge clk);
      wr <= 1'b0;
   endtask

   task automatic get(input logic [ADDR_W-1:0] a, input logic [WORD_W-1:0] e);
      @(posedge clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge clk);
      rd <= 1'b0;
      #1;
      chk(rdata, {16'h0000, e});
   endtask

   function automatic logic taken_of(input logic [2:0] c, input logic [WORD_W-1:0] s);
      case (c)
         COND_NE: taken_of = !s[SR_Z];
         COND_EQ: taken_of = s[SR_Z];
         COND_NC: taken_of = !s[SR_C];
         COND_C:  taken_of = s[SR_C];
         COND_N:  taken_of = s[SR_N];
         COND_GE: taken_of = !(s[SR_N] ^ s[SR_V]);
         COND_L:  taken_of = s[SR_N] ^ s[SR_V];
         default: taken_of = 1'b1;
      endcase
   endfunction

   // ----
   // scenarios
   // ----
   task automatic t_reset();
      for (int a = 0; a <= 32; a += 4)
         get(a[ADDR_W-1:0], 16'h0000);
      put(OFS_SR, 16'hFFFF);
      get(OFS_SR, 16'h013F);
   endtask

   task automatic t_jumps();
      logic [WORD_W-1:0] pats [6];
      logic [WORD_W-1:0] s;
      logic [OFS_W-1:0]  o;
      logic              t;
      pats = '{16'h0000, 16'h0001, 16'h0002, 16'h0004, 16'h0100, 16'h0104};
      for (int c = 0; c < 8; c++)
         for (int p = 0; p < 6; p++)
         begin
            s = pats[p] | 16'h0038;
            o = p[0] ? 10'h200 : 10'h1FF;
            t = taken_of(c[2:0], s);
            put(OFS_SR, s);
            put(OFS_PC, 16'h8000);
            put(OFS_INSTR, {JMP_OPC, c[2:0], o});
            get(OFS_PC, t ? 16'h8000 + {{5{o[9]}}, o, 1'b0} : 16'h8000);
            get(OFS_STAT, {14'h0, 1'b1, t});
            get(OFS_SR, s);
            n_taken += t;
         end
      get(OFS_CNT, n_taken[WORD_W-1:0]);
   endtask

   task automatic t_move();
      put(OFS_SR, 16'h013F);
      put(OFS_SRC, 16'hA5C3);
      put(OFS_DST, 16'h1234);
      put(OFS_INSTR, 16'h4005);
      get(OFS_DST, 16'hA5C3);
      get(OFS_SRC, 16'hA5C3);
      get(OFS_STAT, 16'h0004);
      get(OFS_SR, 16'h013F);
      put(OFS_DST, 16'h1234);
      put(OFS_INSTR, 16'h4045);
      get(OFS_DST, 16'h00C3);
      put(OFS_DST, 16'h1234);
      put(OFS_INSTR, 16'h40C5);
      get(OFS_DST, 16'h12C3);
      put(OFS_DST, 16'h1234);
      put(OFS_INSTR, 16'h4303);
      get(OFS_DST, 16'h1234);
      get(OFS_STAT, 16'h0014);
      get(OFS_SR, 16'h013F);
   endtask

   // an opcode that is neither jump nor move only marks itself in the status
   task automatic t_undef();
      put(OFS_CNT, 16'h7FFF);
      put(OFS_INSTR, 16'hF123);
      get(OFS_STAT, 16'h0008);
      get(OFS_DST, 16'h1234);
      get(OFS_PC, 16'h7C00);
      get(OFS_CNT, 16'h7FFF);
      get(OFS_SR, 16'h013F);
   endtask

   task automatic report_and_stop();
      $display("mismatches=%0d checks=%0d", n_mismatch, tests_run);
      if (n_mismatch == 0 && tests_run > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   always @(posedge clk)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_mismatch++;
         report_and_stop();
      end
   end

   initial
   begin
      nrst = 1'b0;
      addr = 8'h00;
      wdata = 32'h00000000;
      wr = 1'b0;
      rd = 1'b0;
      repeat (5) @(posedge clk);
      nrst <= 1'b1;
      t_reset();
      t_jumps();
      t_move();
      t_undef();
      report_and_stop();
   end
endmodule
`default_nettype wire
